// ### core/pbr_cfg.svh
`ifndef PBR_CFG_SVH
`define PBR_CFG_SVH
// Summary of operation
// R1 - In combined mode a reset starts only when both buttons are held together for the whole setup delay.
// R2 - The setup delay is 2 s with the select input low, 6 s when floating and 10 s when high.
// R3 - In independent mode only the primary button needs the setup delay and the instant input resets at once.
// R4 - The instant input acts on its rising edge and, after a reset, its release must stay low 240 ms before re-arming.
// R5 - When the input levels have held for the setup delay one reset pulse of the timeout length is issued.
// R6 - A press shorter than the setup delay never causes a reset.
// R7 - Reset is asserted while the supply-low indication is active.
// R8 - Reset stays asserted for the timeout period after the supply-low indication clears.
// R9 - The battery-low output follows the battery comparator, apart from the reset logic.
// R10 - Both button inputs are active low.
// R11 - The instant input is active high and its level is set by the outside circuit.
// R12 - The setup counter restarts from zero whenever a required button is released early.
// R13 - Each button input passes a two-stage synchroniser before use.

// ****************************************************************
// Timing
// ****************************************************************
`define PBR_CLK_HZ        40000000
`define PBR_DELAY_LOW_S   2
`define PBR_DELAY_OPEN_S  6
`define PBR_DELAY_HIGH_S  10
`define PBR_DEBOUNCE_MS   240
`define PBR_TIMEOUT_MS    200
`define PBR_DELAY_LOW_CYC  (`PBR_DELAY_LOW_S * `PBR_CLK_HZ)
`define PBR_DELAY_OPEN_CYC (`PBR_DELAY_OPEN_S * `PBR_CLK_HZ)
`define PBR_DELAY_HIGH_CYC (`PBR_DELAY_HIGH_S * `PBR_CLK_HZ)
`define PBR_DEBOUNCE_CYC   (`PBR_DEBOUNCE_MS * (`PBR_CLK_HZ / 1000))
`define PBR_TIMEOUT_CYC    (`PBR_TIMEOUT_MS * (`PBR_CLK_HZ / 1000))
`define PBR_CNT_W          32
`endif

// ### core/pbr_pkg.sv
package pbr_pkg;
  typedef enum logic [1:0]
  {
    PBR_SEL_LOW  = 2'h0,
    PBR_SEL_OPEN = 2'h1,
    PBR_SEL_HIGH = 2'h3
  } pbr_sel_t;

  typedef enum logic [1:0]
  {
    PBR_ST_IDLE  = 2'h0,
    PBR_ST_PULSE = 2'h1,
    PBR_ST_WAIT  = 2'h3
  } pbr_state_t;
endpackage

// ### core/pbr_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pbr_sync_if;
  logic [2:0] raw;
  logic [2:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface
`default_nettype wire

// ### core/pbr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pbr_sync
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  pbr_sync_if.dst   sif
);
  logic [2:0] stage1_ff;
  logic [2:0] stage2_ff;
  logic [2:0] nxt_stage1;
  logic [2:0] nxt_stage2;

  // Button levels idle released (high); instant input idles low
  always_comb
  begin
    nxt_stage1 = stage1_ff;
    nxt_stage2 = stage2_ff;
    if (clkEn)
    begin
      nxt_stage1 = sif.raw;  // R13
      nxt_stage2 = stage1_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_ff <= 3'h3;
      stage2_ff <= 3'h3;
    end
    else
    begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign sif.synced = stage2_ff;
endmodule // pbr_sync
`default_nettype wire

// ### core/pbr_reset_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbr_cfg.svh"
module pbr_reset_supervisor
  import pbr_pkg::*;
#(
  parameter logic              INDEPENDENT  = 1'b0,
  parameter logic [31:0]       DELAY_LOW    = `PBR_DELAY_LOW_CYC,
  parameter logic [31:0]       DELAY_OPEN   = `PBR_DELAY_OPEN_CYC,
  parameter logic [31:0]       DELAY_HIGH   = `PBR_DELAY_HIGH_CYC,
  parameter logic [31:0]       DEBOUNCE_CYC = `PBR_DEBOUNCE_CYC,
  parameter logic [31:0]       TIMEOUT_CYC  = `PBR_TIMEOUT_CYC
)
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       primary_button_n,
  input  wire logic       secondary_button_n,
  input  wire logic       instant_trigger_in,
  input  wire pbr_sel_t   delay_select_tristate,
  input  wire logic       supplyLow,
  input  wire logic       batteryBelow,
  output logic            resetOut_n,
  output logic            battery_low_n
);
  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  pbr_sync_if sif ();
  assign sif.raw = {instant_trigger_in, secondary_button_n, primary_button_n};

  pbr_sync u_sync
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clkEn (clkEn),
    .sif   (sif)
  );

  logic priPress;
  logic secPress;
  logic instLvl;
  assign priPress = ~sif.synced[0];  // R10
  assign secPress = ~sif.synced[1];  // R10
  assign instLvl  = sif.synced[2];  // R11

  logic heldReq;
  always_comb
  begin
    if (INDEPENDENT)
      heldReq = priPress;             // R3
    else
      heldReq = priPress & secPress;  // R1
  end

  function automatic logic [31:0] delay_for(input pbr_sel_t s);
    case (s)
      PBR_SEL_LOW:  delay_for = DELAY_LOW;   // R2
      PBR_SEL_HIGH: delay_for = DELAY_HIGH;  // R2
      default:      delay_for = DELAY_OPEN;  // R2
    endcase
  endfunction

  // ****************************************************************
  // Setup delay and instant trigger
  // ****************************************************************
  logic [31:0] holdCnt_ff;
  logic [31:0] nxt_holdCnt;
  logic        holdDone_ff;
  logic        nxt_holdDone;
  logic        instPrev_ff;
  logic        nxt_instPrev;
  logic        instArmed_ff;
  logic        nxt_instArmed;
  logic [31:0] debCnt_ff;
  logic [31:0] nxt_debCnt;
  logic        holdFire;
  logic        instFire;
  pbr_state_t  state_ff;

  always_comb
  begin
    nxt_holdCnt   = holdCnt_ff;
    nxt_holdDone  = holdDone_ff;
    nxt_instPrev  = instPrev_ff;
    nxt_instArmed = instArmed_ff;
    nxt_debCnt    = debCnt_ff;
    holdFire      = 1'b0;
    instFire      = 1'b0;
    if (clkEn)
    begin
      if (!heldReq)
      begin
        nxt_holdCnt  = 32'h0;  // R12
        nxt_holdDone = 1'b0;
      end
      else if (!holdDone_ff)
      begin
        if (holdCnt_ff + 32'h1 >= delay_for(delay_select_tristate))
        begin
          holdFire     = 1'b1;  // R5
          nxt_holdDone = 1'b1;  // One pulse per press
        end
        else
          nxt_holdCnt = holdCnt_ff + 32'h1;  // R6
      end
      nxt_instPrev = instLvl;
      if (INDEPENDENT)
      begin
        if (instArmed_ff && instLvl && !instPrev_ff)
        begin
          instFire      = 1'b1;  // R3
          nxt_instArmed = 1'b0;
          nxt_debCnt    = 32'h0;
        end
        else if (!instArmed_ff && state_ff != PBR_ST_PULSE)
        begin
          // Release must stay low for the whole debounce window
          if (instLvl)
            nxt_debCnt = 32'h0;  // R4
          else if (debCnt_ff + 32'h1 >= DEBOUNCE_CYC)
            nxt_instArmed = 1'b1;  // R4
          else
            nxt_debCnt = debCnt_ff + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      holdCnt_ff   <= 32'h0;
      holdDone_ff  <= 1'b0;
      instPrev_ff  <= 1'b0;
      instArmed_ff <= 1'b1;
      debCnt_ff    <= 32'h0;
    end
    else
    begin
      holdCnt_ff   <= nxt_holdCnt;
      holdDone_ff  <= nxt_holdDone;
      instPrev_ff  <= nxt_instPrev;
      instArmed_ff <= nxt_instArmed;
      debCnt_ff    <= nxt_debCnt;
    end
  end

  // ****************************************************************
  // Reset pulse generator
  // ****************************************************************
  pbr_state_t  nxt_state;
  logic [31:0] pulseCnt_ff;
  logic [31:0] nxt_pulseCnt;
  logic        rstOut_ff;
  logic        nxt_rstOut;
  logic        batLow_ff;
  logic        nxt_batLow;

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_pulseCnt = pulseCnt_ff;
    nxt_rstOut   = rstOut_ff;
    nxt_batLow   = batLow_ff;
    if (clkEn)
    begin
      nxt_batLow = ~batteryBelow;  // R9
      case (state_ff)
        PBR_ST_IDLE:
        begin
          nxt_rstOut = 1'b1;
          if (supplyLow)
          begin
            nxt_state  = PBR_ST_WAIT;  // R7
            nxt_rstOut = 1'b0;
          end
          else if (holdFire || instFire)
          begin
            nxt_state    = PBR_ST_PULSE;  // R5
            nxt_pulseCnt = 32'h0;
            nxt_rstOut   = 1'b0;
          end
        end
        PBR_ST_WAIT:
        begin
          nxt_rstOut = 1'b0;  // R7
          if (!supplyLow)
          begin
            nxt_state    = PBR_ST_PULSE;  // R8
            nxt_pulseCnt = 32'h0;
          end
        end
        PBR_ST_PULSE:
        begin
          nxt_rstOut = 1'b0;
          if (supplyLow)
            nxt_state = PBR_ST_WAIT;  // R7
          else if (pulseCnt_ff + 32'h1 >= TIMEOUT_CYC)
          begin
            nxt_state  = PBR_ST_IDLE;  // R8
            nxt_rstOut = 1'b1;
          end
          else
            nxt_pulseCnt = pulseCnt_ff + 32'h1;
        end
        default:
        begin
          nxt_state  = PBR_ST_IDLE;
          nxt_rstOut = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff    <= PBR_ST_IDLE;
      pulseCnt_ff <= 32'h0;
      rstOut_ff   <= 1'b1;
      batLow_ff   <= 1'b1;
    end
    else
    begin
      state_ff    <= nxt_state;
      pulseCnt_ff <= nxt_pulseCnt;
      rstOut_ff   <= nxt_rstOut;
      batLow_ff   <= nxt_batLow;
    end
  end

  assign resetOut_n    = rstOut_ff;
  assign battery_low_n = batLow_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_supply_holds_rst: assert property (@(posedge mclk) // R7
    disable iff (!rst_n) (clkEn && supplyLow) |=> !resetOut_n)
    else $error("Reset not asserted under low supply");

  a_short_press_free: assert property (@(posedge mclk) // R6
    disable iff (!rst_n) (!heldReq) |-> !holdFire)
    else $error("Reset fired without held buttons");

  a_counter_restart: assert property (@(posedge mclk) // R12
    disable iff (!rst_n) (clkEn && !heldReq) |=> holdCnt_ff == 32'h0)
    else $error("Setup counter not restarted");

  a_pulse_starts: assert property (@(posedge mclk) // R5
    disable iff (!rst_n)
    (clkEn && holdFire && state_ff == PBR_ST_IDLE && !supplyLow)
      |=> !resetOut_n && state_ff == PBR_ST_PULSE)
    else $error("Reset pulse missing after setup delay");

  a_combined_both: assert property (@(posedge mclk) // R1
    disable iff (!rst_n) holdFire && !INDEPENDENT |-> priPress && secPress)
    else $error("Combined reset without both buttons");

  a_delay_select: assert property (@(posedge mclk) // R2
    disable iff (!rst_n)
    holdFire |-> holdCnt_ff + 32'h1 >= delay_for(delay_select_tristate))
    else $error("Setup delay shorter than selected");

  a_debounce_arm: assert property (@(posedge mclk) // R4
    disable iff (!rst_n)
    $rose(instArmed_ff) |-> $past(debCnt_ff) + 32'h1 >= DEBOUNCE_CYC)
    else $error("Instant input re-armed early");

  a_battery_follow: assert property (@(posedge mclk) // R9
    disable iff (!rst_n) clkEn |=> battery_low_n == !$past(batteryBelow))
    else $error("Battery low output mismatch");

  a_recovery_hold: assert property (@(posedge mclk) // R8
    disable iff (!rst_n)
    (clkEn && state_ff == PBR_ST_WAIT && !supplyLow)
      |=> state_ff == PBR_ST_PULSE && pulseCnt_ff == 32'h0)
    else $error("Recovery timeout not started");

  a_instant_fires: assert property (@(posedge mclk) // R3
    disable iff (!rst_n)
    (instFire && state_ff == PBR_ST_IDLE && !supplyLow) |=> !resetOut_n)
    else $error("Instant input gave no reset");

  a_enable_freeze: assert property (@(posedge mclk) // R5
    disable iff (!rst_n) !clkEn |=> $stable(state_ff) && $stable(holdCnt_ff))
    else $error("State moved while clock enable was low");
endmodule // pbr_reset_supervisor
`default_nettype wire

// ### tb/pbr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Host reset input: counts pulses, times the last one
// ****
module pbr_host_model
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic resetIn_n,
  output int        pulseCnt,
  output int        width
);
  logic prev_ff;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_ff  <= 1'b1;
      pulseCnt <= 0;
      width    <= 0;
    end
    else
    begin
      prev_ff <= resetIn_n;
      if (!resetIn_n)
        width <= prev_ff ? 1 : width + 1;
      if (!resetIn_n && prev_ff)
        pulseCnt <= pulseCnt + 1;
    end
  end
endmodule // pbr_host_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pbr_pkg::*;
  localparam int DL = 20;
  localparam int DO = 60;
  localparam int DH = 100;
  localparam int DB = 24;
  localparam int TO = 16;
  logic      mclk, rst_n, clkEn, pb0N, pb1N, pbIN, inst, supLow, batBelow;
  pbr_sel_t  sel;
  logic      rstOut_n, batLow_n, rstInd_n;
  int        pulseCnt, width, error_cnt, n_tests, n, expP;

  pbr_reset_supervisor #(.DELAY_LOW(DL), .DELAY_OPEN(DO), .DELAY_HIGH(DH),
    .DEBOUNCE_CYC(DB), .TIMEOUT_CYC(TO)) DUT (.mclk(mclk), .rst_n(rst_n),
    .clkEn(clkEn), .primary_button_n(pb0N), .secondary_button_n(pb1N),
    .instant_trigger_in(inst), .delay_select_tristate(sel),
    .supplyLow(supLow), .batteryBelow(batBelow), .resetOut_n(rstOut_n),
    .battery_low_n(batLow_n));
  // Independent variant: the secondary button is ignored there
  pbr_reset_supervisor #(.INDEPENDENT(1'b1), .DELAY_LOW(DL),
    .DELAY_OPEN(DO), .DELAY_HIGH(DH), .DEBOUNCE_CYC(DB),
    .TIMEOUT_CYC(TO)) DUT_IND (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
    .primary_button_n(pbIN), .secondary_button_n(pb1N),
    .instant_trigger_in(inst), .delay_select_tristate(sel),
    .supplyLow(1'b0), .batteryBelow(1'b0), .resetOut_n(rstInd_n),
    .battery_low_n());
  pbr_host_model HOST (.mclk(mclk), .rst_n(rst_n), .resetIn_n(rstOut_n),
    .pulseCnt(pulseCnt), .width(width));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g)
    begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Samples on the falling edge so registered outputs have settled
  task automatic waitv(ref logic s, input logic v, input int lim);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end while (s !== v && n < lim);
  endtask
  task press(input logic p0, input logic p1);
    @(posedge mclk);
    pb0N <= p0;
    pb1N <= p1;
  endtask

  task t_select;
    int d[3];
    pbr_sel_t s[3];
    d = '{DL, DO, DH};
    s = '{PBR_SEL_LOW, PBR_SEL_OPEN, PBR_SEL_HIGH};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk);
      sel <= s[i];
      press(1'b0, 1'b0);
      waitv(rstOut_n, 1'b0, d[i] + 20);
      chk("setup delay", 1, n >= d[i] && n <= d[i] + 6);
      waitv(rstOut_n, 1'b1, TO + 20);
      chk("pulse width", TO, width);
      expP++;
      // Holding on must not fire a second pulse
      cyc(d[i] + 8);
      chk("pulse count", expP, pulseCnt);
      press(1'b1, 1'b1);
      cyc(4);
    end
    $display("select test done");
  endtask

  task t_short;
    @(posedge mclk);
    sel <= PBR_SEL_LOW;
    press(1'b0, 1'b0);
    cyc(DL - 5);
    press(1'b1, 1'b1);
    cyc(2);
    press(1'b0, 1'b0);
    waitv(rstOut_n, 1'b0, DL + 20);
    chk("restart delay", 1, n >= DL && n <= DL + 6);
    waitv(rstOut_n, 1'b1, TO + 20);
    expP++;
    press(1'b1, 1'b1);
    press(1'b0, 1'b1);
    cyc(DL + 20);
    chk("primary alone", expP, pulseCnt);
    press(1'b1, 1'b0);
    cyc(DL + 20);
    chk("secondary alone", expP, pulseCnt);
    press(1'b1, 1'b1);
    $display("short press test done");
  endtask

  task t_supply;
    @(posedge mclk);
    supLow <= 1'b1;
    waitv(rstOut_n, 1'b0, 4);
    chk("supply reset", 1, n <= 2);
    cyc(30);
    supLow <= 1'b0;
    waitv(rstOut_n, 1'b1, TO + 10);
    chk("supply hold", 1, n >= TO && n <= TO + 3);
    @(posedge mclk);
    batBelow <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("battery low", 0, batLow_n);
    chk("reset idle", 1, rstOut_n);
    @(posedge mclk);
    batBelow <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("battery ok", 1, batLow_n);
    $display("supply test done");
  endtask

  // A press made while frozen only starts counting once enabled again
  task t_enable;
    @(posedge mclk);
    clkEn <= 1'b0;
    press(1'b0, 1'b0);
    cyc(DL + 10);
    @(negedge mclk);
    chk("frozen output", 1, rstOut_n);
    @(posedge mclk);
    clkEn <= 1'b1;
    waitv(rstOut_n, 1'b0, DL + 20);
    chk("enable delay", 1, n >= DL && n <= DL + 6);
    waitv(rstOut_n, 1'b1, TO + 20);
    chk("enable pulse", TO, width);
    press(1'b1, 1'b1);
    cyc(4);
    $display("enable test done");
  endtask

  task t_instant;
    @(posedge mclk);
    inst <= 1'b1;
    waitv(rstInd_n, 1'b0, 6);
    chk("instant reset", 0, rstInd_n);
    waitv(rstInd_n, 1'b1, TO + 8);
    @(posedge mclk);
    inst <= 1'b0;
    cyc(DB / 2);
    inst <= 1'b1;
    waitv(rstInd_n, 1'b0, 10);
    chk("bounce ignored", 1, rstInd_n);
    @(posedge mclk);
    inst <= 1'b0;
    cyc(DB + 4);
    inst <= 1'b1;
    waitv(rstInd_n, 1'b0, 6);
    chk("rearmed", 0, rstInd_n);
    waitv(rstInd_n, 1'b1, TO + 8);
    @(posedge mclk);
    inst <= 1'b0;
    pbIN <= 1'b0;
    waitv(rstInd_n, 1'b0, DL + 20);
    chk("primary delay", 1, n >= DL && n <= DL + 6);
    waitv(rstInd_n, 1'b1, TO + 8);
    @(posedge mclk);
    pbIN <= 1'b1;
    $display("instant test done");
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Whole run is near 900 cycles; this margin only cuts a hang
  initial
  begin
    cyc(20000);
    error_cnt++;
    end_of_test;
  end
  initial
  begin
    {rst_n, inst, supLow, batBelow} = 4'h0;
    {pb0N, pb1N, pbIN} = 3'h7;
    clkEn = 1'b1;
    sel = PBR_SEL_LOW;
    error_cnt = 0;
    n_tests = 0;
    expP = 0;
    repeat (5) @(posedge mclk);
    chk("reset level", 1, rstOut_n);
    rst_n <= 1'b1;
    cyc(2);
    t_select;
    t_short;
    t_supply;
    t_enable;
    t_instant;
    end_of_test;
  end
endmodule // tb
`default_nettype wire
